/* core/pad_port_a.v */
// port a data register with direction-dependent readback and upper pin muxing
// assumes an axi4-lite master on aclk; pins already synchronous to aclk
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pad_map.vh"
// Overview of operation
// - eight-bit read/write output data register
// - output pins read back stored data bit
// - input pins read back the pin level
// - reset and hardware standby clear data
// - software standby holds data register
// - modes 3,4,6: top pin is address 20
// - other modes: timer b, else port/pattern
// - top pin feeds timer b capture input
// - modes 1,2,5: chip select 4 when enabled
// - modes 3,4,6: cs4, else address 21 while address21_enable is low, else timer/port/pattern
// - mode 7: second pin timer/port/pattern only
// - timer a output on pwm or io code
// - second pin port/pattern from direction bits
// - direction 1 output; top fixed in addr modes
module pad_port_a (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // standby and mode
  input wire hw_standby,
  input wire sw_standby,
  input wire [2:0] mode,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // peripheral sources
  input wire [7:0] pattern_out,
  input wire timer2_a_pin_out,
  input wire timer2_b_pin_out,
  input wire address20,
  input wire address21,
  input wire chip_select4_n,
  // pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  // timer capture inputs
  output reg timer2_a_capture,
  output reg timer2_b_capture
);
  reg [7:0] data_ff;
  reg [7:0] dir_ff;
  reg [15:0] ctrl_ff;
  reg [3:0] awaddr_ff;
  reg aw_have_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg w_have_ff;
  reg [7:0] nxt_data;
  reg [7:0] nxt_dir;
  reg [15:0] nxt_ctrl;
  reg [31:0] rd_word;
  reg rd_err;
  reg [7:0] nxt_pin_out;
  reg [7:0] nxt_pin_oe;

  // ----------------------------------------
  // register address decode
  // ----------------------------------------
  localparam [2:0] sel_data = 3'h0;
  localparam [2:0] sel_dir = 3'h1;
  localparam [2:0] sel_ctrl = 3'h2;
  localparam [2:0] sel_stat = 3'h3;
  localparam [2:0] sel_none = 3'h4;

  // one decoder selects the register for both bus directions; bresp uses its own compare, so unmapped writes below the status offset answer OKAY
  function [2:0] pad_reg_sel;
    input [3:0] addr;
    begin
      if (addr == `PAD_OFS_DATA) begin
        pad_reg_sel = sel_data;
      end else if (addr == `PAD_OFS_DIR) begin
        pad_reg_sel = sel_dir;
      end else if (addr == `PAD_OFS_CTRL) begin
        pad_reg_sel = sel_ctrl;
      end else if (addr == `PAD_OFS_STAT) begin
        pad_reg_sel = sel_stat;
      end else begin
        pad_reg_sel = sel_none;
      end
    end
  endfunction

  // modes whose top pin is tied to the address bus
  function pad_addr_mode;
    input [2:0] m;
    begin
      pad_addr_mode = (m == 3'h3) || (m == 3'h4) || (m == 3'h6);
    end
  endfunction

  wire [2:0] top_fn;
  wire [2:0] second_fn;
  wire top_capture;
  wire addr_mode = pad_addr_mode(mode);
  wire [7:0] dir_eff = {dir_ff[7] | addr_mode, dir_ff[6:0]};
  // a pending response holds off the next write so bresp cannot be overwritten
  wire wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
  wire [2:0] wr_sel = pad_reg_sel(awaddr_ff);
  wire [2:0] rd_sel = pad_reg_sel(s_axi_araddr);
  // capture a listens only while the second pin is a port or pattern pin
  wire sec_capture = ctrl_ff[`PAD_CTRL_IOA_LO + 2] &&
    ((second_fn == `PAD_FN_IN) || (second_fn == `PAD_FN_OUT) || (second_fn == `PAD_FN_PAT));

  // ----------------------------------------
  // pin function selection
  // ----------------------------------------
  pad_pin_sel u_sel (
    .mode(mode),
    .top_pin_direction_bit(dir_eff[7]),
    .second_pin_direction_bit(dir_eff[6]),
    .top_pin_pattern_enable(ctrl_ff[`PAD_CTRL_TOP_PAT]),
    .second_pin_pattern_enable(ctrl_ff[`PAD_CTRL_SEC_PAT]),
    .timer2_pulse_width_mode(ctrl_ff[`PAD_CTRL_TIMER2_PULSE_WIDTH_MODE]),
    .timer2_b_ctrl(ctrl_ff[`PAD_CTRL_IOB_LO +: 3]),
    .timer2_a_ctrl(ctrl_ff[`PAD_CTRL_IOA_LO +: 3]),
    .chip_select4_enable(ctrl_ff[`PAD_CTRL_CHIP_SELECT4_ENABLE]),
    .address21_enable(ctrl_ff[`PAD_CTRL_ADDRESS21_ENABLE]),
    .top_fn(top_fn),
    .second_fn(second_fn),
    .top_capture(top_capture)
  );

  function pad_fn_level;
    input [2:0] fn;
    input data_bit;
    input pat_bit;
    input tmr_bit;
    input addr_bit;
    input cs_bit;
    begin
      case (fn)
        `PAD_FN_OUT: pad_fn_level = data_bit;
        `PAD_FN_PAT: pad_fn_level = pat_bit;
        `PAD_FN_TMR: pad_fn_level = tmr_bit;
        `PAD_FN_ADDR: pad_fn_level = addr_bit;
        `PAD_FN_CS: pad_fn_level = cs_bit;
        default: pad_fn_level = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always @* begin
    nxt_pin_out = data_ff & dir_eff;
    nxt_pin_oe = dir_eff;
    nxt_pin_out[7] = pad_fn_level(top_fn, data_ff[7], pattern_out[7],
      timer2_b_pin_out, address20, 1'b0);
    nxt_pin_oe[7] = (top_fn != `PAD_FN_IN);
    nxt_pin_out[6] = pad_fn_level(second_fn, data_ff[6], pattern_out[6],
      timer2_a_pin_out, address21, chip_select4_n);
    nxt_pin_oe[6] = (second_fn != `PAD_FN_IN);
    // lower pins carry no pattern data; their enables are out of scope: plain port
  end

  // ----------------------------------------
  // register write path
  // ----------------------------------------
  always @* begin
    nxt_data = data_ff;
    nxt_dir = dir_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_go && wstrb_ff[0]) begin
      if (wr_sel == sel_data) begin
        nxt_data = wdata_ff[7:0];
      end else if (wr_sel == sel_dir) begin
        nxt_dir = wdata_ff[7:0];
      end else if (wr_sel == sel_ctrl) begin
        nxt_ctrl[7:0] = wdata_ff[7:0];
      end
    end
    if (wr_go && wstrb_ff[1] && (wr_sel == sel_ctrl)) begin
      nxt_ctrl[15:8] = wdata_ff[15:8];
    end
  end

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  always @* begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    // only taken on the ar handshake, so pin levels are those of that edge
    if (rd_sel == sel_data) begin
      rd_word[7:0] = (data_ff & dir_eff) | (pin_in & ~dir_eff);
    end else if (rd_sel == sel_dir) begin
      rd_word[7:0] = 8'hff; // direction is write-only; reads as all ones
    end else if (rd_sel == sel_ctrl) begin
      rd_word[15:0] = ctrl_ff;
    end else if (rd_sel == sel_stat) begin
      rd_word[10:0] = {top_capture, second_fn, top_fn, mode, dir_eff[7]};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      data_ff <= `PAD_DATA_RST;
      dir_ff <= `PAD_DIR_RST;
      ctrl_ff <= `PAD_CTRL_RST;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      timer2_a_capture <= 1'b0;
      timer2_b_capture <= 1'b0;
    end else begin
      // software standby still accepts nothing new but keeps contents
      if (!sw_standby) begin
        data_ff <= nxt_data;
        dir_ff <= nxt_dir;
        ctrl_ff <= nxt_ctrl;
      end
      pin_out <= nxt_pin_out;
      pin_oe <= nxt_pin_oe;
      timer2_a_capture <= sec_capture && pin_in[6];
      timer2_b_capture <= top_capture && pin_in[7];
    end
  end

  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PAD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PAD_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      awaddr_ff <= 4'h0;
      aw_have_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      w_have_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_have_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ((awaddr_ff == `PAD_OFS_STAT) || (awaddr_ff > `PAD_OFS_STAT)) ?
          `PAD_RESP_SLVERR : `PAD_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_err ? `PAD_RESP_SLVERR : `PAD_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // pad_port_a

/* core/pad_map.vh */
// port a data register and pin select: register map and field positions
// assumes inclusion by the pad core files only
`ifndef PAD_MAP_VH
`define PAD_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PAD_OFS_DATA 4'h0
`define PAD_OFS_DIR 4'h4
`define PAD_OFS_CTRL 4'h8
`define PAD_OFS_STAT 4'hc
// ----------------------------------------
// reset values
// ----------------------------------------
`define PAD_DATA_RST 8'h00
`define PAD_DIR_RST 8'h00
`define PAD_DIR_RST_ADDR 8'h80
`define PAD_CTRL_RST 16'h0000
// ----------------------------------------
// control register fields
// ----------------------------------------
`define PAD_CTRL_MODE_LO 0
`define PAD_CTRL_TOP_PAT 3
`define PAD_CTRL_SEC_PAT 4
`define PAD_CTRL_TIMER2_PULSE_WIDTH_MODE 5
`define PAD_CTRL_IOB_LO 6
`define PAD_CTRL_IOA_LO 9
`define PAD_CTRL_CHIP_SELECT4_ENABLE 12
`define PAD_CTRL_ADDRESS21_ENABLE 13
// ----------------------------------------
// pin function codes
// ----------------------------------------
`define PAD_FN_IN 3'h0
`define PAD_FN_OUT 3'h1
`define PAD_FN_PAT 3'h2
`define PAD_FN_TMR 3'h3
`define PAD_FN_ADDR 3'h4
`define PAD_FN_CS 3'h5
// ----------------------------------------
// axi responses
// ----------------------------------------
`define PAD_RESP_OKAY 2'h0
`define PAD_RESP_SLVERR 2'h2
`endif

/* core/pad_pin_sel.v */
// pin function selection for the two upper port pins
// assumes all inputs are registered state from the same clock domain
`timescale 1ns/1ps
`include "pad_map.vh"
module pad_pin_sel (
  // operating mode
  input wire [2:0] mode,
  // direction and pattern enables
  input wire top_pin_direction_bit,
  input wire second_pin_direction_bit,
  input wire top_pin_pattern_enable,
  input wire second_pin_pattern_enable,
  // timer channel 2 settings
  input wire timer2_pulse_width_mode,
  input wire [2:0] timer2_b_ctrl,
  input wire [2:0] timer2_a_ctrl,
  // bus control enables
  input wire chip_select4_enable,
  input wire address21_enable,
  // selected functions
  output reg [2:0] top_fn,
  output reg [2:0] second_fn,
  output reg top_capture
);
  function [2:0] pad_port_fn;
    input dir;
    input pat;
    begin
      if (!dir) begin
        pad_port_fn = `PAD_FN_IN;
      end else if (!pat) begin
        pad_port_fn = `PAD_FN_OUT;
      end else begin
        pad_port_fn = `PAD_FN_PAT;
      end
    end
  endfunction

  wire addr_mode = (mode == 3'h3) || (mode == 3'h4) || (mode == 3'h6);
  wire cs_mode = (mode == 3'h1) || (mode == 3'h2) || (mode == 3'h5);
  wire b_out = !timer2_b_ctrl[2] && (timer2_b_ctrl[1:0] != 2'h0);
  wire a_out = timer2_pulse_width_mode ||
    (!timer2_a_ctrl[2] && (timer2_a_ctrl[1:0] != 2'h0));
  wire [2:0] sec_port = a_out ? `PAD_FN_TMR :
    pad_port_fn(second_pin_direction_bit, second_pin_pattern_enable);

  always @* begin
    if (addr_mode) begin
      top_fn = `PAD_FN_ADDR;
    end else if (b_out) begin
      top_fn = `PAD_FN_TMR;
    end else begin
      top_fn = pad_port_fn(top_pin_direction_bit, top_pin_pattern_enable);
    end
    top_capture = !addr_mode && !b_out && !timer2_pulse_width_mode &&
      timer2_b_ctrl[2];
    if ((cs_mode || addr_mode) && chip_select4_enable) begin
      second_fn = `PAD_FN_CS;
    end else if (addr_mode && !address21_enable) begin
      second_fn = `PAD_FN_ADDR;
    end else begin
      second_fn = sec_port;
    end
  end
endmodule // pad_pin_sel

/* tb/pad_ext_pins.sv */
// external circuitry on the port pins
// assumes pin_out and pin_oe come straight from the port block
`timescale 1ns/1ps
module pad_ext_pins (
  // pins
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // a driven pin shows the port's level, an undriven one the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pad_ext_pins

/* tb/pad_port_a_chk.sv */
// port checker for pad_port_a, bound to every instance
// assumes mode stays static outside reset
`timescale 1ns/1ps
module pad_port_a_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // watched ports
  input wire hw_standby,
  input wire [2:0] mode,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire address20,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire timer2_b_capture
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire am = (mode == 3'h3) || (mode == 3'h4) || (mode == 3'h6);
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wbusy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  // the pin register lags one cycle, so the source is compared one cycle back
  property p_addr20;
    am && $past(aresetn) && !$past(hw_standby) |-> pin_oe[7] && pin_out[7] == $past(address20);
  endproperty
  a_addr20: assert property (p_addr20) else $error("top pin not address");
  property p_cap;
    am && $past(aresetn) |-> !timer2_b_capture;
  endproperty
  a_cap: assert property (p_cap) else $error("capture in address mode");
  property p_hw;
    $past(hw_standby) |-> pin_oe == 8'h00;
  endproperty
  a_hw: assert property (p_hw) else $error("pins driven in standby");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_am: cover property (am && pin_oe[7]);
endmodule // pad_port_a_chk
bind pad_port_a pad_port_a_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .hw_standby(hw_standby), .mode(mode), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .address20(address20),
  .pin_out(pin_out), .pin_oe(pin_oe), .timer2_b_capture(timer2_b_capture));

/* tb/tb.sv */
// bench for the port a data register and upper pin select
// assumes the port block, its checker and the pin model are compiled first
`timescale 1ns/1ps
module tb;
  reg aclk, aresetn, hw_standby, sw_standby, awvalid, wvalid, bready, arvalid, rready;
  reg [3:0] awaddr, araddr, wstrb;
  reg [31:0] wdata, rdv;
  reg [2:0] mode;
  reg [7:0] pat, ext;
  reg t2a, t2b, a20, a21, cs4_n, done;
  reg [1:0] resp, rr;
  wire awready, wready, bvalid, arready, rvalid, cap_b, cap_a;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_in, pin_out, pin_oe;
  integer err_count, checks_done, cyc;
  pad_port_a u_dut (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .mode(mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pattern_out(pat), .timer2_a_pin_out(t2a), .timer2_b_pin_out(t2b), .address20(a20),
    .address21(a21), .chip_select4_n(cs4_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .timer2_a_capture(cap_a), .timer2_b_capture(cap_b));
  pad_ext_pins u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task chk(input string n, input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [3:0] s);
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          resp = bresp;
          bready <= 1'b0;
          done = 1;
        end
      end
      // one idle edge so the next call never re-raises bready in this step
      @(posedge aclk);
    end
  endtask
  task rdchk(input [3:0] a, input [7:0] e);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rdv = rdata;
          rr = rresp;
          rready <= 1'b0;
          done = 1;
        end
      end
      @(posedge aclk);
      chk("read", rdv[7:0], e);
    end
  endtask
  task pins(input integer b, input [1:0] m, input [1:0] e);
    begin
      repeat (3) @(posedge aclk);
      chk("pin", {pin_oe[b], pin_out[b]} & m, e);
    end
  endtask
  // mode only changes under reset
  task do_reset(input [2:0] m);
    begin
      aresetn <= 1'b0;
      mode <= m;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      do_reset(3'h1);
      rdchk(4'h0, 8'hda);
      chk("rresp", rr, 2'h0);
      rdchk(4'h2, 8'h00);
      chk("rresp", rr, 2'h2);
      wr(4'h0, 32'ha5, 4'h1);
      wr(4'h4, 32'hff, 4'h1);
      rdchk(4'h0, 8'ha5);
      wr(4'h4, 32'h0f, 4'h1);
      rdchk(4'h0, 8'hd5);
      wr(4'h0, 32'hff, 4'h0);
      rdchk(4'h0, 8'hd5);
      wr(4'hc, 32'hff, 4'hf);
      chk("bresp", resp, 2'h2);
    end
  endtask
  task t_standby;
    begin
      sw_standby <= 1'b1;
      wr(4'h0, 32'h3c, 4'h1);
      sw_standby <= 1'b0;
      rdchk(4'h0, 8'hd5);
      hw_standby <= 1'b1;
      @(posedge aclk);
      hw_standby <= 1'b0;
      wr(4'h4, 32'hff, 4'h1);
      rdchk(4'h0, 8'h00);
    end
  endtask
  task t_top;
    begin
      wr(4'h8, 32'h0040, 4'h3);
      t2b <= 1'b1;
      pins(7, 2'h3, 2'h3);
      t2b <= 1'b0;
      pins(7, 2'h3, 2'h2);
      wr(4'h8, 32'h0100, 4'h3);
      wr(4'h4, 32'h00, 4'h1);
      pins(7, 2'h2, 2'h0);
      chk("capture", cap_b, 1'b1);
      wr(4'h4, 32'h80, 4'h1);
      wr(4'h8, 32'h0108, 4'h3);
      pat <= 8'h80;
      pins(7, 2'h3, 2'h3);
    end
  endtask
  task t_second;
    begin
      do_reset(3'h1);
      wr(4'h8, 32'h1000, 4'h3);
      cs4_n <= 1'b1;
      pins(6, 2'h3, 2'h3);
      do_reset(3'h3);
      a21 <= 1'b1;
      a20 <= 1'b1;
      pins(6, 2'h3, 2'h3);
      pins(7, 2'h3, 2'h3);
      wr(4'h8, 32'h0800, 4'h3);
      pins(6, 2'h3, 2'h3);
      chk("capture a", cap_a, 1'b0);
      wr(4'h8, 32'h2800, 4'h3);
      pins(6, 2'h2, 2'h0);
      chk("capture a", cap_a, 1'b1);
      cs4_n <= 1'b0;
      a21 <= 1'b0;
      do_reset(3'h7);
      wr(4'h8, 32'h3020, 4'h3);
      t2a <= 1'b1;
      pins(6, 2'h3, 2'h3);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  initial begin
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    aresetn <= 1'b0;
    mode <= 3'h1;
    {hw_standby, sw_standby, awvalid, wvalid, bready, arvalid, rready} <= 7'h00;
    {awaddr, araddr, wstrb, wdata} <= 44'h0;
    {pat, t2a, t2b, a20, a21, cs4_n} <= 13'h0000;
    ext <= 8'hda;
    t_regs;
    t_standby;
    t_top;
    t_second;
    end_of_test;
  end
endmodule // tb
